// ===== bus_timing_consts.vh
`ifndef BUS_TIMING_CONSTS_VH
`define BUS_TIMING_CONSTS_VH

// register byte offsets
`define OFS_TIMING_HIGH 4'h0
`define OFS_TIMING_LOW 4'h4
`define OFS_STATUS 4'h8

// timing high register fields (two-bit length codes)
`define HI_NOLATCH_WRITE_LSB 0
`define HI_LATCHED_WRITE_LSB 2
`define HI_NOLATCH_READ_LSB 4
`define HI_LATCHED_READ_LSB 6

// timing low register fields
`define LO_WRITE_HOLD_EXTEND 0
`define LO_WRITE_WIDTH 1
`define LO_LATCH_WIDTH 2
`define LO_BUS8 3
`define LO_NOLATCH_CODE_LSB 4
`define LO_LATCHED_CODE_LSB 6

// status register fields
`define ST_BUSY 0
`define ST_CFG_ERR 1
`define ST_HOLD_ERR 2
`define ST_STALLED 3

// reset values
`define RST_TIMING_HIGH 8'hff
`define RST_TIMING_LOW 8'hf1

// cycle kinds
`define KIND_CODE 2'h0
`define KIND_READ 2'h1
`define KIND_WRITE 2'h2

// timing counts, in half bus clocks (one ref_clk cycle each)
`define HALF_LATCH_NARROW 5'h01
`define HALF_LATCH_WIDE 5'h03
`define HALF_LATCH_GAP 5'h01
`define HALF_WR_NARROW 5'h02
`define HALF_WR_WIDE 5'h04
`define HALF_HOLD_EXT 5'h02
`define HALF_NOLATCH_BASE 5'h02
`define HALF_LATCHED_BASE 5'h04
`define HALF_READ_STALL_CUT 5'h02

`endif

// ===== external_bus_cycle_timing.v
`timescale 1ns/1ps
`include "bus_timing_consts.vh"

module external_bus_cycle_timing #(
  parameter ADDR_W = 20
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // register bus
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  // cycle requests from the core
  input wire reqValid,
  output reg reqReady,
  input wire [1:0] reqKind,
  input wire reqLatch,
  input wire reqWide,
  input wire [1:0] reqByteEn,
  input wire [ADDR_W-1:0] reqAddr,
  input wire [15:0] reqWrData,
  // read results
  output reg [15:0] rdData,
  output reg rdValid,
  // external bus pins
  output reg [ADDR_W-1:0] busAddr,
  output reg addrLatch,
  output reg codeFetchStrobeN,
  output reg readStrobeN,
  output reg writeStrobeLowByteN,
  output reg writeStrobeHighByteN,
  output reg [15:0] busDataOut,
  output reg busDataOe,
  input wire [15:0] busDataIn,
  input wire stallIn
);

  // total cycle length in half clocks
  function [4:0] cycLen;
    input [1:0] k;
    input l;
    input [7:0] hi, lo;
    reg [1:0] f;
    begin
      case (k)
        `KIND_CODE: f = l ? lo[`LO_LATCHED_CODE_LSB+1:`LO_LATCHED_CODE_LSB] :
          lo[`LO_NOLATCH_CODE_LSB+1:`LO_NOLATCH_CODE_LSB];
        `KIND_READ: f = l ? hi[`HI_LATCHED_READ_LSB+1:`HI_LATCHED_READ_LSB] :
          hi[`HI_NOLATCH_READ_LSB+1:`HI_NOLATCH_READ_LSB];
        default: f = l ? hi[`HI_LATCHED_WRITE_LSB+1:`HI_LATCHED_WRITE_LSB] :
          hi[`HI_NOLATCH_WRITE_LSB+1:`HI_NOLATCH_WRITE_LSB];
      endcase
      if (l || k == `KIND_WRITE)
        cycLen = {2'h0, f, 1'b0} + `HALF_LATCHED_BASE;
      else
        cycLen = {2'h0, f, 1'b0} + `HALF_NOLATCH_BASE;
    end
  endfunction
  // latch pulse width in half clocks
  function [4:0] latchW;
    input l;
    input [7:0] lo;
    latchW = !l ? 5'h00 :
      (lo[`LO_LATCH_WIDTH] ? `HALF_LATCH_WIDE : `HALF_LATCH_NARROW);
  endfunction
  // write strobe width in half clocks
  function [4:0] wrW;
    input [7:0] lo;
    wrW = lo[`LO_WRITE_WIDTH] ? `HALF_WR_WIDE : `HALF_WR_NARROW;
  endfunction
  // write data hold in half clocks
  function [4:0] holdH;
    input [7:0] lo;
    holdH = lo[`LO_WRITE_HOLD_EXTEND] ? `HALF_HOLD_EXT : 5'h00;
  endfunction
  // first half clock of the bus strobe
  function [4:0] strbStart;
    input [1:0] k;
    input l;
    input [7:0] hi, lo;
    begin
      if (k == `KIND_WRITE)
        strbStart = cycLen(k, l, hi, lo) - wrW(lo) - holdH(lo);
      else if (l)
        strbStart = latchW(l, lo) + `HALF_LATCH_GAP;
      else
        strbStart = 5'h00;
    end
  endfunction
  // half clock just past the bus strobe
  function [4:0] strbEnd;
    input [1:0] k;
    input l;
    input [7:0] hi, lo;
    strbEnd = cycLen(k, l, hi, lo) - ((k == `KIND_WRITE) ? holdH(lo) : 5'h00);
  endfunction
  // first half clock with write data driven
  function [4:0] dataStart;
    input l;
    input [7:0] lo;
    dataStart = l ? latchW(l, lo) + `HALF_LATCH_GAP : 5'h00;
  endfunction
  // strobe length against which stall is sampled, zero when unstretchable
  function [4:0] stallLen;
    input [1:0] k;
    input l;
    input [7:0] hi, lo;
    reg [4:0] w;
    begin
      w = strbEnd(k, l, hi, lo) - strbStart(k, l, hi, lo);
      case (k)
        `KIND_CODE: stallLen = w;
        `KIND_WRITE: stallLen = wrW(lo);
        `KIND_READ: stallLen = (w > `HALF_READ_STALL_CUT) ? w - `HALF_READ_STALL_CUT :
          5'h00;
        default: stallLen = 5'h00;
      endcase
    end
  endfunction
  // timing combination yields a sane cycle
  function cfgOk;
    input [1:0] k;
    input l;
    input [7:0] hi, lo;
    reg [4:0] lead;
    begin
      lead = dataStart(l, lo);
      if (k == `KIND_WRITE)
        cfgOk = (wrW(lo) + holdH(lo) + lead) <= cycLen(k, l, hi, lo);
      else if (k == `KIND_READ || k == `KIND_CODE)
        cfgOk = (lead + 5'h01) <= cycLen(k, l, hi, lo);
      else
        cfgOk = 1'b0;
    end
  endfunction

  reg [7:0] timingHigh_q, timingLow_q;
  reg cfgErr_q, holdErr_q, stalled_q, busy_q, latch_q, wide_q, phase_q;
  reg [1:0] kind_q, be_q;
  reg [4:0] cnt_q;
  reg [ADDR_W-1:0] addr_q;
  reg [15:0] wdata_q;
  reg pendValid_q, pendLatch_q, pendWide_q;
  reg [1:0] pendKind_q, pendBe_q;
  reg [ADDR_W-1:0] pendAddr_q;
  reg [15:0] pendData_q;
  reg busy_d, latch_d, wide_d, phase_d, pendValid_d, rdValid_d;
  reg setCfgErr, setHoldErr, hold, endTick, take, inStrobe;
  reg [1:0] kind_d, be_d;
  reg [4:0] cnt_d, sStart, sEnd;
  reg [ADDR_W-1:0] addr_d;
  reg [15:0] wdata_d, rdData_d;
  wire busReq = read | write;
  wire busHit = busReq & ~waitrequest;
  wire accept = reqValid & reqReady;

  // cycle sequencer: counts half clocks, stretches on stall, chains halves
  always @*
  begin
    busy_d = busy_q;
    kind_d = kind_q;
    latch_d = latch_q;
    wide_d = wide_q;
    phase_d = phase_q;
    cnt_d = cnt_q;
    be_d = be_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdData_d = rdData;
    rdValid_d = 1'b0;
    setCfgErr = 1'b0;
    setHoldErr = 1'b0;
    hold = busy_q && stallIn && stallLen(kind_q, latch_q, timingHigh_q, timingLow_q) != 5'h00 &&
      cnt_q == strbStart(kind_q, latch_q, timingHigh_q, timingLow_q) +
      stallLen(kind_q, latch_q, timingHigh_q, timingLow_q) - 5'h01;
    endTick = busy_q && !hold &&
      (cnt_q + 5'h01) == cycLen(kind_q, latch_q, timingHigh_q, timingLow_q);
    take = pendValid_q && (!busy_q || (endTick && !(wide_q && !phase_q)));
    if (busy_q && !endTick)
      cnt_d = hold ? cnt_q : cnt_q + 5'h01;
    if (endTick && kind_q != `KIND_WRITE)
    begin
      if (wide_q && !phase_q)
        rdData_d[7:0] = busDataIn[7:0];
      else if (wide_q)
        rdData_d[15:8] = busDataIn[7:0];
      else
        rdData_d = busDataIn;
      rdValid_d = !(wide_q && !phase_q);
    end
    if (endTick)
    begin
      if (wide_q && !phase_q)
      begin
        // second byte: no latch pulse, strobe stays on, low address rises
        phase_d = 1'b1;
        latch_d = 1'b0;
        cnt_d = 5'h00;
        addr_d[0] = 1'b1;
      end
      else
        busy_d = 1'b0;
    end
    if (take)
    begin
      if (pendKind_q == `KIND_WRITE && !timingLow_q[`LO_WRITE_HOLD_EXTEND])
        setHoldErr = 1'b1;
      else if (!cfgOk(pendKind_q, pendLatch_q, timingHigh_q, timingLow_q))
        setCfgErr = 1'b1;
      else
      begin
        // back-to-back no-latch fetches keep the fetch strobe low
        busy_d = 1'b1;
        kind_d = pendKind_q;
        latch_d = pendLatch_q;
        wide_d = pendWide_q && pendKind_q == `KIND_READ && timingLow_q[`LO_BUS8];
        phase_d = 1'b0;
        cnt_d = 5'h00;
        be_d = pendBe_q;
        addr_d = pendAddr_q;
        wdata_d = pendData_q;
      end
    end
    pendValid_d = accept ? 1'b1 : (take ? 1'b0 : pendValid_q);
  end
  // pin levels derived from the next state so they leave flip-flops
  always @*
  begin
    sStart = strbStart(kind_d, latch_d, timingHigh_q, timingLow_q);
    sEnd = strbEnd(kind_d, latch_d, timingHigh_q, timingLow_q);
    inStrobe = busy_d && cnt_d >= sStart && cnt_d < sEnd;
  end
  // sequencer and pin registers
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      kind_q <= `KIND_CODE;
      latch_q <= 1'b0;
      wide_q <= 1'b0;
      phase_q <= 1'b0;
      cnt_q <= 5'h00;
      be_q <= 2'h0;
      addr_q <= {ADDR_W{1'b0}};
      wdata_q <= 16'h0000;
      pendValid_q <= 1'b0;
      pendKind_q <= `KIND_CODE;
      pendLatch_q <= 1'b0;
      pendWide_q <= 1'b0;
      pendBe_q <= 2'h0;
      pendAddr_q <= {ADDR_W{1'b0}};
      pendData_q <= 16'h0000;
      reqReady <= 1'b0;
      rdData <= 16'h0000;
      rdValid <= 1'b0;
      busAddr <= {ADDR_W{1'b0}};
      addrLatch <= 1'b0;
      codeFetchStrobeN <= 1'b1;
      readStrobeN <= 1'b1;
      writeStrobeLowByteN <= 1'b1;
      writeStrobeHighByteN <= 1'b1;
      busDataOut <= 16'h0000;
      busDataOe <= 1'b0;
      stalled_q <= 1'b0;
    end
    else
    begin
      busy_q <= busy_d;
      kind_q <= kind_d;
      latch_q <= latch_d;
      wide_q <= wide_d;
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      be_q <= be_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      pendValid_q <= pendValid_d;
      if (accept)
      begin
        pendKind_q <= reqKind;
        pendLatch_q <= reqLatch;
        pendWide_q <= reqWide;
        pendBe_q <= reqByteEn;
        pendAddr_q <= reqAddr;
        pendData_q <= reqWrData;
      end
      reqReady <= !pendValid_d;
      rdData <= rdData_d;
      rdValid <= rdValid_d;
      busAddr <= addr_d;
      addrLatch <= busy_d && cnt_d < latchW(latch_d, timingLow_q);
      codeFetchStrobeN <= !(inStrobe && kind_d == `KIND_CODE);
      readStrobeN <= !(inStrobe && kind_d == `KIND_READ);
      writeStrobeLowByteN <= !(inStrobe && kind_d == `KIND_WRITE && be_d[0]);
      writeStrobeHighByteN <= !(inStrobe && kind_d == `KIND_WRITE && be_d[1]);
      busDataOut <= wdata_d;
      busDataOe <= busy_d && kind_d == `KIND_WRITE &&
        cnt_d >= dataStart(latch_d, timingLow_q);
      stalled_q <= hold;
    end
  end

  // register slave: one wait cycle, then the access completes
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      timingHigh_q <= `RST_TIMING_HIGH;
      timingLow_q <= `RST_TIMING_LOW;
      cfgErr_q <= 1'b0;
      holdErr_q <= 1'b0;
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end
    else
    begin
      waitrequest <= !(busReq && waitrequest);
      if (read && waitrequest)
      begin
        case (address)
          `OFS_TIMING_HIGH: readdata <= {24'h000000, timingHigh_q};
          `OFS_TIMING_LOW: readdata <= {24'h000000, timingLow_q};
          `OFS_STATUS: readdata <= {28'h0000000, stalled_q, holdErr_q, cfgErr_q, busy_q};
          default: readdata <= 32'h00000000;
        endcase
      end
      if (busHit && write && address == `OFS_TIMING_HIGH)
        timingHigh_q <= writedata[7:0];
      if (busHit && write && address == `OFS_TIMING_LOW)
        timingLow_q <= writedata[7:0];
      // sticky flags, write one to clear, a new event wins
      cfgErr_q <= setCfgErr | (cfgErr_q &
        ~(busHit & write & address == `OFS_STATUS & writedata[`ST_CFG_ERR]));
      holdErr_q <= setHoldErr | (holdErr_q &
        ~(busHit & write & address == `OFS_STATUS & writedata[`ST_HOLD_ERR]));
    end
  end

endmodule

// ===== ebct_props.sv
`timescale 1ns/1ps
module ebct_props (
  // clock, reset and register bus
  input wire ref_clk,
  input wire rst,
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire waitrequest,
  // requests and results
  input wire reqValid,
  input wire reqReady,
  input wire [1:0] reqKind,
  input wire rdValid,
  // bus pins
  input wire addrLatch,
  input wire codeFetchStrobeN,
  input wire readStrobeN,
  input wire writeStrobeLowByteN,
  input wire busDataOe,
  input wire stallIn
);
  reg [7:0] loQ;
  // shadow of the timing low register
  always @(posedge ref_clk)
    if (rst)
      loQ <= 8'hf1;
    else if (write && !waitrequest && address == 4'h4)
      loQ <= writedata[7:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("register access not answered");
  a_latch_narrow: assert property ($rose(addrLatch) && !loQ[2] |=> !addrLatch)
    else $error("narrow latch pulse wrong");
  a_latch_wide: assert property ($rose(addrLatch) && loQ[2] |=> addrLatch ##1 addrLatch ##1 !addrLatch)
    else $error("wide latch pulse wrong");
  a_latch_gap: assert property ($fell(addrLatch) |-> readStrobeN && codeFetchStrobeN)
    else $error("strobe without half clock gap");
  a_write_narrow: assert property ($fell(writeStrobeLowByteN) && !loQ[1] && !stallIn
    |=> !writeStrobeLowByteN ##1 writeStrobeLowByteN)
    else $error("narrow write strobe wrong");
  a_write_wide: assert property ($fell(writeStrobeLowByteN) && loQ[1] && !stallIn
    |=> !writeStrobeLowByteN [*3] ##1 writeStrobeLowByteN)
    else $error("wide write strobe wrong");
  a_data_hold: assert property ($rose(writeStrobeLowByteN) && loQ[0] |-> busDataOe [*2])
    else $error("write data hold too short");
  a_write_data: assert property (!writeStrobeLowByteN |-> busDataOe)
    else $error("write strobe without data");
  a_read_source: assert property (rdValid |-> !($past(readStrobeN) && $past(codeFetchStrobeN)))
    else $error("read result without strobe");
  a_hold_refuse: assert property (reqValid && reqReady && reqKind == 2'h2 && !loQ[0]
    |=> writeStrobeLowByteN [*8])
    else $error("write run without hold extend");
  // main scenarios
  cover property ($rose(addrLatch) && loQ[2]);
  cover property (rdValid);
  cover property (!writeStrobeLowByteN && stallIn);
endmodule
bind external_bus_cycle_timing ebct_props u_props (.ref_clk, .rst, .address, .read, .write,
  .writedata, .waitrequest, .reqValid, .reqReady, .reqKind, .rdValid, .addrLatch,
  .codeFetchStrobeN, .readStrobeN, .writeStrobeLowByteN, .busDataOe, .stallIn);

// ===== ext_mem_model.sv
`timescale 1ns/1ps
module ext_mem_model (
  // pins from the device
  input wire ref_clk,
  input wire [19:0] busAddr,
  input wire codeFetchStrobeN,
  input wire readStrobeN,
  input wire writeStrobeLowByteN,
  input wire [15:0] busDataOut,
  // answers to the device
  output reg [15:0] busDataIn,
  output wire stallIn,
  // bench control and capture
  input wire [3:0] stallLen,
  output reg [7:0] wrLow
);
  reg [3:0] lowCnt = 4'h0;
  reg [3:0] lastAddr = 4'h0;
  wire rdOn = !readStrobeN || !codeFetchStrobeN;
  wire anyOn = rdOn || !writeStrobeLowByteN;
  // stall window restarts on a new strobe or a low address change
  assign stallIn = anyOn && lowCnt < stallLen;
  initial busDataIn = 16'h0;
  initial wrLow = 8'h0;
  // strobe tracking, read data pattern, write capture
  always @(posedge ref_clk)
  begin
    lastAddr <= busAddr[3:0];
    if (!anyOn || busAddr[3:0] != lastAddr)
      lowCnt <= 4'h0;
    else if (lowCnt != 4'hf)
      lowCnt <= lowCnt + 4'h1;
    busDataIn <= rdOn ? {busAddr[7:0] ^ 8'hc3, busAddr[7:0] ^ 8'h3c} : ~busDataIn;
    if (!writeStrobeLowByteN)
      wrLow <= busDataOut[7:0];
  end
endmodule

// ===== tb_external_bus_cycle_timing.sv
`timescale 1ns/1ps
module tb_external_bus_cycle_timing;
  // design inputs
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] address = 4'h0;
  reg read = 1'b0;
  reg write = 1'b0;
  reg [31:0] writedata = 32'h0;
  reg reqValid = 1'b0;
  reg [1:0] reqKind = 2'h0;
  reg reqLatch = 1'b0;
  reg reqWide = 1'b0;
  reg [1:0] reqByteEn = 2'h3;
  reg [19:0] reqAddr = 20'h0;
  reg [15:0] reqWrData = 16'h0;
  reg [3:0] stallLen = 4'h0;
  // design outputs and model lines
  wire [31:0] readdata;
  wire [15:0] rdData, busDataOut, busDataIn;
  wire [19:0] busAddr;
  wire [7:0] wrLow;
  wire waitrequest, reqReady, rdValid, addrLatch, codeFetchStrobeN, readStrobeN;
  wire writeStrobeLowByteN, writeStrobeHighByteN, busDataOe, stallIn;
  integer err_count = 0;
  integer checks_done = 0;
  integer cnt [0:3];
  integer len [0:3];
  integer i, j, k, f, w, exp, lead, leadCnt, hiSeen;
  reg [31:0] q;
  reg [19:0] a;
  reg [15:0] lastRd;
  wire [3:0] act = {addrLatch, !codeFetchStrobeN, !readStrobeN, !writeStrobeLowByteN};
  external_bus_cycle_timing dut (.ref_clk, .rst, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .reqValid, .reqReady, .reqKind, .reqLatch, .reqWide,
    .reqByteEn, .reqAddr, .reqWrData, .rdData, .rdValid, .busAddr, .addrLatch,
    .codeFetchStrobeN, .readStrobeN, .writeStrobeLowByteN, .writeStrobeHighByteN,
    .busDataOut, .busDataOe, .busDataIn, .stallIn);
  ext_mem_model mem (.ref_clk, .busAddr, .codeFetchStrobeN, .readStrobeN,
    .writeStrobeLowByteN, .busDataOut, .busDataIn, .stallIn, .stallLen, .wrLow);
  // 200 MHz clock
  initial
  begin
    forever #2.5 ref_clk = !ref_clk;
  end
  // pulse widths in half clocks, write data lead and last read result
  always @(posedge ref_clk)
  begin
    for (k = 0; k < 4; k = k + 1)
      if (act[k])
        cnt[k] = cnt[k] + 1;
      else if (cnt[k] != 0)
      begin
        len[k] = cnt[k];
        cnt[k] = 0;
      end
    if (act[0] && leadCnt != 0)
      lead = leadCnt;
    leadCnt = (busDataOe && writeStrobeLowByteN) ? leadCnt + 1 : 0;
    if (!writeStrobeHighByteN)
      hiSeen = hiSeen + 1;
    if (rdValid)
      lastRd = rdData;
  end
  task report_and_stop;
  begin
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task timeout;
  begin
    err_count = err_count + 1;
    report_and_stop;
  end
  endtask
  task chk(input string what, input [31:0] seen, input [31:0] expv);
  begin
    checks_done = checks_done + 1;
    if (seen !== expv)
    begin
      err_count = err_count + 1;
      $display("CHECK FAILED %0s expected %h seen %h", what, expv, seen);
    end
  end
  endtask
  // one register access, held until waitrequest is seen low
  task bus(input wr, input [3:0] ad, input [7:0] d, output [31:0] rq);
    integer n;
  begin
    @(posedge ref_clk);
    address <= ad;
    writedata <= {24'h0, d};
    read <= !wr;
    write <= wr;
    n = 0;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge ref_clk);
      n = n + 1;
    end
    if (n >= 50)
      timeout;
    rq = readdata;
    read <= 1'b0;
    write <= 1'b0;
  end
  endtask
  task cfg(input [7:0] hi, input [7:0] lo);
  begin
    bus(1'b1, 4'h0, hi, q);
    bus(1'b1, 4'h4, lo, q);
    bus(1'b1, 4'h8, 8'h06, q);
  end
  endtask
  // hand one cycle request over when the slot is free
  task send(input [1:0] kd, input lt, input wd, input [19:0] ra);
    integer n;
  begin
    n = 0;
    @(posedge ref_clk);
    while (reqReady !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      n = n + 1;
    end
    if (n >= 50)
      timeout;
    reqKind <= kd;
    reqLatch <= lt;
    reqWide <= wd;
    reqAddr <= ra;
    reqWrData <= {8'h0, ra[7:0]};
    reqValid <= 1'b1;
    @(posedge ref_clk);
    reqValid <= 1'b0;
  end
  endtask
  task idle;
    integer n;
  begin
    repeat (3) @(posedge ref_clk);
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 40)
    begin
      bus(1'b0, 4'h8, 8'h0, q);
      n = n + 1;
    end
    if (q[0] !== 1'b0)
      timeout;
    repeat (3) @(posedge ref_clk);
  end
  endtask
  task op(input [1:0] kd, input lt, input wd, input [19:0] ra);
  begin
    for (j = 0; j < 4; j = j + 1)
      len[j] = 0;
    lead = 0;
    hiSeen = 0;
    lastRd = 16'h0;
    send(kd, lt, wd, ra);
    idle;
  end
  endtask
  // main sequence
  initial
  begin
    for (j = 0; j < 4; j = j + 1)
      cnt[j] = 0;
    leadCnt = 0;
    hiSeen = 0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, 4'h0, 8'h0, q);
    chk("timing high reset", q, 32'hff);
    bus(1'b0, 4'h4, 8'h0, q);
    chk("timing low reset", q, 32'hf1);
    bus(1'b1, 4'hc, 8'h55, q);
    bus(1'b0, 4'hc, 8'h0, q);
    chk("unmapped", q, 32'h0);
    // fetch and read strobes over every length code, latch mode and width
    for (i = 0; i < 32; i = i + 1)
    begin
      f = i % 4;
      w = ((i / 4) % 2) ? 3 : 1;
      a = {12'h0, i[5:0], 2'h0};
      cfg({4{f[1:0]}}, {f[1:0], f[1:0], 1'b0, w == 3, 2'h1});
      exp = ((i / 8) % 2) ? 2 * f + 3 - w : 2 * f + 2;
      op(i / 16, (i / 8) % 2, 1'b0, a);
      bus(1'b0, 4'h8, 8'h0, q);
      if (exp > 0)
      begin
        chk("strobe width", len[2 - i / 16], exp);
        chk("latch width", len[3], ((i / 8) % 2) ? w : 0);
        chk("read data", lastRd, {a[7:0] ^ 8'hc3, a[7:0] ^ 8'h3c});
      end
      else
        chk("cfg error", q[1], 1'b1);
    end
    // writes over length code, strobe width and latch mode
    for (i = 0; i < 16; i = i + 1)
    begin
      f = i % 4;
      w = ((i / 4) % 2) ? 4 : 2;
      a = {12'h0, i[5:0], 2'h2};
      cfg({4{f[1:0]}}, {6'h0, w == 4, 1'b1});
      reqByteEn <= (i % 2) ? 2'h1 : 2'h3;
      exp = ((i / 8) % 2) ? 2 * f - w : 2 * f + 2 - w;
      op(2'h2, (i / 8) % 2, 1'b0, a);
      bus(1'b0, 4'h8, 8'h0, q);
      if (exp > 0)
      begin
        chk("write width", len[0], w);
        chk("data lead", lead, exp);
        chk("write data", wrLow, a[7:0]);
        chk("high byte strobe", hiSeen, (i % 2) ? 0 : w);
      end
      else if (exp < 0)
        chk("cfg error", q[1], 1'b1);
    end
    reqByteEn <= 2'h3;
    // write without extended hold is refused
    cfg(8'hff, 8'hf0);
    op(2'h2, 1'b0, 1'b0, 20'h7);
    bus(1'b0, 4'h8, 8'h0, q);
    chk("hold refused", {q[2], len[0][3:0]}, 5'h10);
    // wide read on byte bus: latched half then no-latch half, one strobe
    cfg(8'h55, 8'h09);
    op(2'h1, 1'b1, 1'b1, 20'h40);
    chk("wide strobe", len[1], 8);
    chk("wide data", lastRd, {8'h41 ^ 8'h3c, 8'h40 ^ 8'h3c});
    // stall against a one-clock read and against a write
    cfg(8'h01, 8'h01);
    stallLen <= 4'h6;
    op(2'h1, 1'b0, 1'b0, 20'h8);
    chk("short read stall", len[1], 2);
    op(2'h2, 1'b0, 1'b0, 20'h9);
    chk("write stalled", len[0] > 2, 1'b1);
    stallLen <= 4'h0;
    // back-to-back no-latch fetches keep the strobe low
    cfg(8'h01, 8'h11);
    for (j = 0; j < 4; j = j + 1)
      len[j] = 0;
    send(2'h0, 1'b0, 1'b0, 20'h10);
    send(2'h0, 1'b0, 1'b0, 20'h12);
    idle;
    chk("fetch burst", len[2], 8);
    report_and_stop;
  end
endmodule
